/* File: inc/spdif_rx_status_map.svh */
// register offsets, field positions, reset values for the receiver status bank
`ifndef SPDIF_RX_STATUS_MAP_SVH
`define SPDIF_RX_STATUS_MAP_SVH
`define ADDR_W 16
`define DATA_W 16
`define OFF_LOCK_STATUS 16'hF600
`define OFF_DECODED_FORMAT 16'hF602
`define OFF_COMPRESSION_CODE 16'hF603
`define OFF_AUTO_RESUME 16'hF604
`define OFF_SYNC_LOST 16'hF605
`define OFF_IRQ_STATUS 16'hF610
`define OFF_IRQ_ENABLE 16'hF611
`define OFF_IRQ_CLEAR 16'hF612
`define OFF_MANUAL_RESUME 16'hF613
`define RIGHT_WL_HI 9
`define RIGHT_WL_LO 6
`define LEFT_WL_HI 5
`define LEFT_WL_LO 2
`define FAMILY_BIT 1
`define PAYLOAD_BIT 0
`define RESUME_BIT 0
`define RESET_VALUE 16'h0000
`define IRQ_W 3
`define IRQ_LOST 0
`define IRQ_RELOCK 1
`define IRQ_STATUS_NEW 2
`endif

/* File: inc/spdif_rx_status_pkg.sv */
// types for the receiver status bank
`default_nettype none
package spdif_rx_status_pkg;
  typedef enum logic [2:0] {
    ST_UNLOCKED = 3'b001,
    ST_PLAYING = 3'b010,
    ST_HELD = 3'b100
  } audio_state_t;
  typedef logic [15:0] word_t;
endpackage : spdif_rx_status_pkg
`default_nettype wire

/* File: rtl/word_size_encoder.sv */
// maps a detected bit count and maximum word to the 4-bit word-length code
`default_nettype none
`include "spdif_rx_status_map.svh"
module word_size_encoder (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [4:0] bits_in,
  input wire logic max24_in,
  output logic [3:0] code_out
);
  logic [3:0] code_r;
  logic [3:0] code_nxt;
  logic [3:0] enc;

  // lookup of the two word families; unknown counts give zero
  always_comb
  begin
    enc = 4'h0;
    if (!max24_in)
    begin
      case (bits_in)
        5'h10: enc = 4'h2;
        5'h11: enc = 4'hC;
        5'h12: enc = 4'h4;
        5'h13: enc = 4'h8;
        5'h14: enc = 4'hA;
        default: enc = 4'h0;
      endcase
    end
    else
    begin
      case (bits_in)
        5'h14: enc = 4'h3;
        5'h15: enc = 4'hD;
        5'h16: enc = 4'h5;
        5'h17: enc = 4'h9;
        5'h18: enc = 4'hB;
        default: enc = 4'h0;
      endcase
    end
    code_nxt = load_in ? enc : code_r;
  end

  // held code, cleared at reset
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      code_r <= 4'h0;
    else
      code_r <= code_nxt;
  end

  assign code_out = code_r;
endmodule : word_size_encoder
`default_nettype wire

/* File: rtl/spdif_rx_status_restart.sv */
// receiver status, decode registers and auto-resume mute control
//
// Overview of operation
// - right word length in bits 9:6
// - left word length in bits 5:2
// - 20-bit max word-length codes
// - 24-bit max word-length codes
// - bit 0: pcm or compressed
// - bit 1: compression family
// - 16-bit compression code register
// - mute whenever the state is not ST_PLAYING
// - resume off: stay muted after relock
// - resume on: unmute on relock, clear flag
// - decode registers reset zero, 15:10 reserved
// - sticky lost flag until resume bit written 1 or relock with resume on
// - lock status bit mirrors lock
//
// The plain strobed port was left to the implementer.
`default_nettype none
`include "spdif_rx_status_map.svh"
module spdif_rx_status_restart (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic lock_in,
  input wire logic status_valid_in,
  input wire logic [4:0] right_bits_in,
  input wire logic [4:0] left_bits_in,
  input wire logic max24_in,
  input wire logic compressed_in,
  input wire logic family_in,
  input wire logic [15:0] code_in,
  output logic mute_out,
  output logic lock_out,
  output logic sync_lost_out,
  output logic irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic lock_r;
  logic lock_nxt;
  logic resume_r;
  logic resume_nxt;
  logic sync_lost_sticky_r;
  logic sync_lost_sticky_nxt;
  logic payload_r;
  logic payload_nxt;
  logic compression_family_r;
  logic compression_family_nxt;
  spdif_rx_status_pkg::word_t compression_code_r;
  spdif_rx_status_pkg::word_t compression_code_nxt;
  spdif_rx_status_pkg::audio_state_t state_r;
  spdif_rx_status_pkg::audio_state_t state_nxt;
  logic [`IRQ_W-1:0] irq_stat_r;
  logic [`IRQ_W-1:0] irq_stat_nxt;
  logic [`IRQ_W-1:0] irq_en_r;
  logic [`IRQ_W-1:0] irq_en_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic mute_r;
  logic irq_r;
  logic [3:0] right_word_size_detected;
  logic [3:0] left_word_size_detected;
  logic refresh;
  logic lost_evt;
  logic relock_evt;
  logic resume_wr;
  logic resume_rise;
  logic manual_kick;
  logic [15:0] decoded_format;

  ////////////////////////////////////////////////////////////////////////////
  // decode refresh only while locked, so stale frames never overwrite
  assign refresh = status_valid_in & lock_in;
  assign lost_evt = lock_r & ~lock_in;
  assign relock_evt = ~lock_r & lock_in;
  assign resume_wr = wr_in & (addr_in == `OFF_AUTO_RESUME);
  assign resume_rise = resume_wr & wdata_in[`RESUME_BIT] & ~resume_r;
  // spare register: any write restarts audio like a resume toggle
  assign manual_kick = (wr_in & (addr_in == `OFF_MANUAL_RESUME)) | resume_rise;

  word_size_encoder u_right (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .load_in(refresh),
    .bits_in(right_bits_in),
    .max24_in(max24_in),
    .code_out(right_word_size_detected)
  );

  word_size_encoder u_left (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .load_in(refresh),
    .bits_in(left_bits_in),
    .max24_in(max24_in),
    .code_out(left_word_size_detected)
  );

  // reserved 15:10 read zero
  assign decoded_format = {6'h00,
    right_word_size_detected,
    left_word_size_detected,
    compression_family_r,
    payload_r};

  ////////////////////////////////////////////////////////////////////////////
  // decoded payload fields; bus writes never reach them
  always_comb
  begin
    payload_nxt = payload_r;
    compression_family_nxt = compression_family_r;
    compression_code_nxt = compression_code_r;
    if (refresh)
    begin
      payload_nxt = compressed_in;
      compression_family_nxt = family_in;
      // code only tracks while compressed; pcm keeps last value
      if (compressed_in)
        compression_code_nxt = code_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      payload_r <= 1'b0;
      compression_family_r <= 1'b0;
      compression_code_r <= `RESET_VALUE;
    end
    else
    begin
      payload_r <= payload_nxt;
      compression_family_r <= compression_family_nxt;
      compression_code_r <= compression_code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock tracking, sticky flag and resume control
  always_comb
  begin
    lock_nxt = lock_in;
    resume_nxt = resume_wr ? wdata_in[`RESUME_BIT] : resume_r;
    sync_lost_sticky_nxt = sync_lost_sticky_r;
    // a loss in the same cycle as the clear wins
    if ((resume_wr & wdata_in[`RESUME_BIT]) | (resume_r & relock_evt))
      sync_lost_sticky_nxt = 1'b0;
    if (lost_evt)
      sync_lost_sticky_nxt = 1'b1;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lock_r <= 1'b0;
      resume_r <= 1'b0;
      sync_lost_sticky_r <= 1'b0;
    end
    else
    begin
      lock_r <= lock_nxt;
      resume_r <= resume_nxt;
      sync_lost_sticky_r <= sync_lost_sticky_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mute machine: held waits for resume bit or a manual kick
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      spdif_rx_status_pkg::ST_UNLOCKED:
        if (lock_in)
          state_nxt = spdif_rx_status_pkg::ST_PLAYING;
      spdif_rx_status_pkg::ST_PLAYING:
        if (!lock_in)
          state_nxt = spdif_rx_status_pkg::ST_HELD;
      spdif_rx_status_pkg::ST_HELD:
        if (lock_in & (resume_r | manual_kick))
          state_nxt = spdif_rx_status_pkg::ST_PLAYING;
        else
          state_nxt = spdif_rx_status_pkg::ST_HELD;
      default:
        state_nxt = spdif_rx_status_pkg::ST_UNLOCKED;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_r <= spdif_rx_status_pkg::ST_UNLOCKED;
    else
      state_r <= state_nxt;
  end

  // mute registered from next state so it leaves with the state
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      mute_r <= 1'b1;
    else
      mute_r <= (state_nxt != spdif_rx_status_pkg::ST_PLAYING);
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, set beats clear
  always_comb
  begin
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_in & (addr_in == `OFF_IRQ_ENABLE))
      irq_en_nxt = wdata_in[`IRQ_W-1:0];
    if (wr_in & (addr_in == `OFF_IRQ_CLEAR))
      irq_stat_nxt = irq_stat_r & ~wdata_in[`IRQ_W-1:0];
    if (lost_evt)
      irq_stat_nxt[`IRQ_LOST] = 1'b1;
    if (relock_evt)
      irq_stat_nxt[`IRQ_RELOCK] = 1'b1;
    if (refresh)
      irq_stat_nxt[`IRQ_STATUS_NEW] = 1'b1;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_en_r <= '0;
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_en_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, data stand the cycle after the strobe; unmapped reads zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (rd_in)
    begin
      case (addr_in)
        `OFF_LOCK_STATUS: rdata_nxt = {15'h0000, lock_r};
        `OFF_DECODED_FORMAT: rdata_nxt = decoded_format;
        `OFF_COMPRESSION_CODE: rdata_nxt = compression_code_r;
        `OFF_AUTO_RESUME: rdata_nxt = {15'h0000, resume_r};
        `OFF_SYNC_LOST: rdata_nxt = {15'h0000, sync_lost_sticky_r};
        `OFF_IRQ_STATUS: rdata_nxt = {13'h0000, irq_stat_r};
        `OFF_IRQ_ENABLE: rdata_nxt = {13'h0000, irq_en_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_r <= 16'h0000;
    else
      rdata_r <= rdata_nxt;
  end

  assign rdata_out = rdata_r;
  assign mute_out = mute_r;
  assign lock_out = lock_r;
  assign sync_lost_out = sync_lost_sticky_r;
  assign irq_out = irq_r;
endmodule : spdif_rx_status_restart
`default_nettype wire

/* File: testbench/spdif_rx_status_restart_monitor.sv */
// port checker for the receiver status bank
`default_nettype none
`include "spdif_rx_status_map.svh"
module spdif_rx_status_restart_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic lock_in,
  input wire logic lock_out,
  input wire logic mute_out,
  input wire logic sync_lost_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // lock seen last cycle but gone now
  wire logic drop = lock_out && !lock_in;
  wire logic kick = wr_in && addr_in == `OFF_AUTO_RESUME && wdata_in[0];
  ////////////////////////////////////////////////////////////////////////////////
  a_mute_on_drop: assert property (drop |=> mute_out)
    else $error("no mute on lock loss");
  a_muted_unlocked: assert property (mute_out && !lock_in |=> mute_out)
    else $error("unmuted without lock");
  a_sticky_set: assert property (drop |=> sync_lost_out)
    else $error("lost flag not set");
  a_sticky_hold: assert property (sync_lost_out && !lock_in && !wr_in |=> sync_lost_out)
    else $error("lost flag dropped");
  a_resume_clears: assert property (kick && lock_in |=> !sync_lost_out)
    else $error("lost flag not cleared");
  a_manual_kick: assert property (kick && lock_in && lock_out |-> ##[1:2] !mute_out)
    else $error("restart did not unmute");
  a_lock_mirror: assert property (1'b1 |=> lock_out == $past(lock_in))
    else $error("lock bit wrong");
  a_reserved_zero: assert property (rd_in && addr_in == `OFF_DECODED_FORMAT
    |=> rdata_out[15:10] == 6'h00)
    else $error("reserved bits set");
  c_drop: cover property (drop);
  c_unmute: cover property (mute_out ##1 !mute_out);
  c_decode_rd: cover property (rd_in && addr_in == `OFF_DECODED_FORMAT);
endmodule : spdif_rx_status_restart_monitor
bind spdif_rx_status_restart spdif_rx_status_restart_monitor mon_u (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .lock_in(lock_in),
  .lock_out(lock_out), .mute_out(mute_out), .sync_lost_out(sync_lost_out));
`default_nettype wire

/* File: testbench/spdif_tx_model.sv */
// transmitter-side model: lock level and channel status updates
`default_nettype none
module spdif_tx_model (
  input wire logic core_clk_in,
  output logic lock_out,
  output logic valid_out,
  output logic [4:0] right_out,
  output logic [4:0] left_out,
  output logic max24_out,
  output logic comp_out,
  output logic family_out,
  output logic [15:0] code_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {lock_out, valid_out, right_out, left_out, max24_out, comp_out} = '0;
  initial {family_out, code_out} = '0;
  task set_lock(input logic v);
    @(posedge core_clk_in);
    lock_out <= v;
  endtask : set_lock
  // fields mean nothing outside the pulse, so right, left and code wander afterwards
  task send(input logic [4:0] r, l, input logic m, c, f, input logic [15:0] k);
    @(posedge core_clk_in);
    {right_out, left_out, max24_out, comp_out, family_out, code_out} <= {r, l, m, c, f, k};
    valid_out <= 1'b1;
    @(posedge core_clk_in);
    valid_out <= 1'b0;
    {right_out, left_out, code_out} <= ~{r, l, k};
  endtask : send
endmodule : spdif_tx_model
`default_nettype wire

/* File: testbench/spdif_rx_status_restart_bench.sv */
// bench for the receiver status bank
`default_nettype none
`include "spdif_rx_status_map.svh"
module spdif_rx_status_restart_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [15:0] wdata;
  wire logic [15:0] rdata, code;
  wire logic lock, vld, m24, comp, fam, mute, lk, lost, irq;
  wire logic [4:0] rb, lb;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [3:0] CD [10] = '{4'h2, 4'hC, 4'h4, 4'h8, 4'hA, 4'h3, 4'hD, 4'h5, 4'h9, 4'hB};
  always #2 clk = ~clk;
  spdif_tx_model tx_u (.core_clk_in(clk), .lock_out(lock), .valid_out(vld), .right_out(rb),
    .left_out(lb), .max24_out(m24), .comp_out(comp), .family_out(fam), .code_out(code));
  spdif_rx_status_restart dut_u (.core_clk_in(clk), .rst_in(rst), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .lock_in(lock),
    .status_valid_in(vld), .right_bits_in(rb), .left_bits_in(lb), .max24_in(m24),
    .compressed_in(comp), .family_in(fam), .code_in(code), .mute_out(mute),
    .lock_out(lk), .sync_lost_out(lost), .irq_out(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      final_report;
    end
  end
  task check(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task wreg(input logic [15:0] a, d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // read data are only valid in the cycle after the strobe
  task rchk(input logic [15:0] a, exp);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask : rchk
  function logic [4:0] wl(input int i);
    return 5'(i < 5 ? 16 + i : 15 + i);
  endfunction : wl
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rchk(`OFF_DECODED_FORMAT, 16'h0000);
    rchk(`OFF_COMPRESSION_CODE, 16'h0000);
    rchk(`OFF_AUTO_RESUME, 16'h0000);
    tx_u.set_lock(1'b1);
    idle(4);
    check(lk, 1'b1);
    rchk(`OFF_LOCK_STATUS, 16'h0001);
  endtask : t_reset
  // left takes a different code of the same family to catch a swap
  task t_decode;
    logic [15:0] k;
    int j;
    k = 16'h0000;
    for (int i = 0; i < 10; i++)
    begin
      j = (i / 5) * 5 + (i + 1) % 5;
      tx_u.send(wl(i), wl(j), i >= 5, i[0], i[1] & i[0], 16'hA5A0 + 16'(i));
      if (i[0])
        k = 16'hA5A0 + 16'(i);
      idle(3);
      rchk(`OFF_DECODED_FORMAT, {6'h00, CD[i], CD[j], i[1] & i[0], i[0]});
      rchk(`OFF_COMPRESSION_CODE, k);
    end
    wreg(`OFF_COMPRESSION_CODE, 16'h0000);
    rchk(`OFF_COMPRESSION_CODE, k);
    // last frame was 24 bits right, 20 bits left (24-bit family), compressed
    wreg(`OFF_DECODED_FORMAT, 16'hFFFF);
    rchk(`OFF_DECODED_FORMAT, 16'h02CD);
  endtask : t_decode
  task t_manual;
    tx_u.set_lock(1'b0);
    idle(3);
    check(mute, 1'b1);
    rchk(`OFF_SYNC_LOST, 16'h0001);
    tx_u.set_lock(1'b1);
    idle(5);
    check(mute, 1'b1);
    check(lost, 1'b1);
    wreg(`OFF_AUTO_RESUME, 16'h0001);
    wreg(`OFF_AUTO_RESUME, 16'h0000);
    idle(2);
    check(mute, 1'b0);
    check(lost, 1'b0);
  endtask : t_manual
  task t_auto;
    wreg(`OFF_AUTO_RESUME, 16'h0001);
    tx_u.set_lock(1'b0);
    idle(3);
    check(mute, 1'b1);
    check(lost, 1'b1);
    tx_u.set_lock(1'b1);
    idle(4);
    check(mute, 1'b0);
    check(lost, 1'b0);
  endtask : t_auto
  task t_irq;
    wreg(`OFF_IRQ_CLEAR, 16'h0007);
    wreg(`OFF_IRQ_ENABLE, 16'h0001);
    tx_u.set_lock(1'b0);
    idle(3);
    check(irq, 1'b1);
    rchk(`OFF_IRQ_STATUS, 16'h0001);
    wreg(`OFF_IRQ_ENABLE, 16'h0000);
    idle(2);
    check(irq, 1'b0);
    wreg(`OFF_IRQ_ENABLE, 16'h0001);
    wreg(`OFF_IRQ_CLEAR, 16'h0001);
    idle(2);
    check(irq, 1'b0);
    rchk(16'hF6FF, 16'h0000);
    rchk(`OFF_IRQ_ENABLE, 16'h0001);
    // relock with resume off stays muted; the spare kick register restarts
    wreg(`OFF_AUTO_RESUME, 16'h0000);
    tx_u.set_lock(1'b1);
    idle(3);
    check(mute, 1'b1);
    check(irq, 1'b0);
    rchk(`OFF_IRQ_STATUS, 16'h0002);
    wreg(`OFF_MANUAL_RESUME, 16'h0000);
    idle(2);
    check(mute, 1'b0);
    check(lost, 1'b1);
  endtask : t_irq
  initial
  begin
    {rst, wr, rd} = 3'h4;
    {addr, wdata} = 32'h00000000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_decode;
    t_manual;
    t_auto;
    t_irq;
    final_report;
  end
endmodule : spdif_rx_status_restart_bench
`default_nettype wire
